//--- logic/sgc_pkg.sv
// Constants for the switch global control register pair.
// Assumes a 100 MHz core clock; the cycle counts FAST_AGE_CYC and MS_TICK_CYC derive from it.
package sgc_pkg;
	// ****************************************
	// Register map
	// ****************************************
	localparam logic [7:0] ADDR_GLOBAL_CONTROL_ZERO = 8'h02;
	localparam logic [7:0] ADDR_GLOBAL_CONTROL_ONE  = 8'h03;
	localparam logic [7:0] SPI_CMD_WRITE            = 8'h02;
	localparam logic [7:0] SPI_CMD_READ             = 8'h03;

	// ****************************************
	// Field positions
	// ****************************************
	localparam int GC0_RSVD_BIT    = 7;
	localparam int GC0_PRIO_LSB    = 4;
	localparam int GC0_PHY_MII_BIT = 3;
	localparam int GC0_SHARE_BIT   = 2;
	localparam int GC0_INTEROP_BIT = 1;
	localparam int GC0_LINK_AGE_BIT = 0;
	localparam int GC1_PASS_ALL_BIT = 7;
	localparam int GC1_RSVD_BIT     = 6;
	localparam int GC1_TX_FC_DIS_BIT = 5;
	localparam int GC1_RX_FC_DIS_BIT = 4;
	localparam int GC1_LEN_CHK_BIT  = 3;
	// Bits 2..0 of the second register belong elsewhere and read as zero
	localparam logic [7:0] GC1_IMPL_MASK = 8'hf8;

	// ****************************************
	// Reset values (strap bits filled in after reset)
	// ****************************************
	localparam logic [7:0] GC0_RESET = 8'h44;
	localparam logic [7:0] GC1_RESET = 8'h00;

	// ****************************************
	// Frame filter constants
	// ****************************************
	localparam logic [15:0] FLOW_CTRL_TYPE  = 16'h8808;
	localparam logic [47:0] FLOW_CTRL_DA    = 48'h0180_c200_0001;
	localparam logic [15:0] MAX_LEN_FIELD   = 16'h05dc;

	// ****************************************
	// Timing
	// ****************************************
	localparam int CLK_MHZ          = 100;
	localparam int FAST_AGE_US      = 800;
	localparam int FAST_AGE_CYC     = FAST_AGE_US * CLK_MHZ;
	localparam int MS_TICK_CYC      = 1000 * CLK_MHZ;
	localparam int NORMAL_AGE_S     = 300;
	localparam int NORMAL_AGE_XTRA_S = 75;
	localparam int NORMAL_AGE_MS    = (NORMAL_AGE_S + NORMAL_AGE_XTRA_S) * 1000;
	localparam int STRAP_SETTLE_CYC = 3;
	localparam int NUM_PORTS        = 5;
endpackage : sgc_pkg

//--- logic/sgc_reg_if.sv
// Register access path between the serial slave and the register bank.
// Single clock domain; the slave is the initiator.
`timescale 1ns/1ns
interface sgc_reg_if;
	logic       wr_en;
	logic [7:0] addr;
	logic [7:0] wdata;
	logic [7:0] rdata;

	modport initiator (output wr_en, output addr, output wdata, input rdata);
	modport target    (input wr_en, input addr, input wdata, output rdata);
endinterface : sgc_reg_if

//--- logic/sgc_spi_slave.sv
// Serial management slave: command byte, address byte, then data bytes
// with address auto-increment. Mode 0; pins are oversampled by clk_i.
// Assumes SCLK well below a quarter of the core clock.
`timescale 1ns/1ns
module sgc_spi_slave (
	// Clock and reset
	input  wire logic clk_i,
	input  wire logic rst_n_i,
	// Pins
	input  wire logic spi_sclk_i,
	input  wire logic spi_cs_n_i,
	input  wire logic spi_mosi_i,
	output logic      spi_miso_o,
	output logic      spi_miso_oe_o,
	// Register access
	sgc_reg_if.initiator bus
);
	import sgc_pkg::*;

	typedef enum logic [1:0] {
		SGC_PH_CMD  = 2'b00,
		SGC_PH_ADDR = 2'b01,
		SGC_PH_DATA = 2'b10
	} sgc_phase_t;

	// ****************************************
	// Pin synchronisers
	// ****************************************
	logic [2:0] sync_a;
	logic [2:0] sync_b;
	logic       sclk_d;

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sync_a <= 3'b010;
			sync_b <= 3'b010;
			sclk_d <= 1'b0;
		end else begin
			sync_a <= {spi_sclk_i, spi_cs_n_i, spi_mosi_i};
			sync_b <= sync_a;
			sclk_d <= sync_b[2];
		end
	end

	logic sclk_rise;
	logic sclk_fall;
	logic cs_act;
	assign sclk_rise = sync_b[2] & ~sclk_d;
	assign sclk_fall = ~sync_b[2] & sclk_d;
	assign cs_act    = ~sync_b[1];

	// ****************************************
	// Byte engine
	// ****************************************
	sgc_phase_t phase;
	sgc_phase_t next_phase;
	logic [2:0] bit_cnt;
	logic [2:0] next_bit_cnt;
	logic [7:0] shift_in;
	logic [7:0] next_shift_in;
	logic [7:0] shift_out;
	logic [7:0] next_shift_out;
	logic [7:0] addr;
	logic [7:0] next_addr;
	logic       is_read;
	logic       next_is_read;
	logic       load;
	logic       next_load;
	logic       wr;
	logic       next_wr;
	logic [7:0] wdata;
	logic [7:0] next_wdata;
	logic [7:0] byte_in;

	always_comb begin
		byte_in        = {shift_in[6:0], sync_b[0]};
		next_phase     = phase;
		next_bit_cnt   = bit_cnt;
		next_shift_in  = shift_in;
		next_shift_out = shift_out;
		next_addr      = addr;
		next_is_read   = is_read;
		next_load      = 1'b0;
		next_wr        = 1'b0;
		next_wdata     = wdata;
		if (!cs_act) begin
			next_phase   = SGC_PH_CMD;
			next_bit_cnt = 3'd0;
		end else if (load || wr) begin
			// Read data is fetched once the address is known
			if (load) begin
				next_shift_out = bus.rdata;
			end
			// Address steps once per data byte, after the access that used it
			next_addr = addr + 8'h01;
		end else if (sclk_fall && (bit_cnt != 3'd0)) begin
			// The fall closing a byte keeps the freshly loaded bit 7 on the pin
			next_shift_out = {shift_out[6:0], 1'b0};
		end else if (sclk_rise) begin
			next_shift_in = byte_in;
			next_bit_cnt  = bit_cnt + 3'd1;
			if (bit_cnt == 3'd7) begin
				unique case (phase)
					SGC_PH_CMD: begin
						next_is_read = (byte_in == SPI_CMD_READ);
						next_phase   = SGC_PH_ADDR;
					end
					SGC_PH_ADDR: begin
						next_addr  = byte_in;
						next_phase = SGC_PH_DATA;
						next_load  = is_read;
					end
					SGC_PH_DATA: begin
						if (is_read) begin
							next_load = 1'b1;
						end else begin
							next_wr    = 1'b1;
							next_wdata = byte_in;
						end
					end
					default: next_phase = SGC_PH_CMD;
				endcase
			end
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			phase     <= SGC_PH_CMD;
			bit_cnt   <= 3'd0;
			shift_in  <= 8'h00;
			shift_out <= 8'h00;
			addr      <= 8'h00;
			is_read   <= 1'b0;
			load      <= 1'b0;
			wr        <= 1'b0;
			wdata     <= 8'h00;
		end else begin
			phase     <= next_phase;
			bit_cnt   <= next_bit_cnt;
			shift_in  <= next_shift_in;
			shift_out <= next_shift_out;
			addr      <= next_addr;
			is_read   <= next_is_read;
			load      <= next_load;
			wr        <= next_wr;
			wdata     <= next_wdata;
		end
	end

	// Write strobe then address step happen on consecutive cycles
	logic wr_d;
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wr_d <= 1'b0;
		end else begin
			wr_d <= wr;
		end
	end

	assign bus.wr_en    = wr;
	assign bus.addr     = wr_d ? addr - 8'h01 : addr;
	assign bus.wdata    = wdata;
	assign spi_miso_o    = shift_out[7];
	assign spi_miso_oe_o = cs_act & is_read & (phase == SGC_PH_DATA);
endmodule : sgc_spi_slave

//--- logic/sgc_top.sv
// Global control register pair of a five-port switch, with the logic the
// fields steer. Registers are reached over the serial management slave.
// Assumes frame and link inputs come from the core clock domain.
`timescale 1ns/1ns
module sgc_top #(
	parameter int POOL_BLOCKS   = 512,
	parameter int FAST_AGE_CYCLES = sgc_pkg::FAST_AGE_CYC,
	parameter int MS_TICK_CYCLES  = sgc_pkg::MS_TICK_CYC,
	parameter int NORMAL_AGE_MSEC = sgc_pkg::NORMAL_AGE_MS
) (
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        reset_n_i,
	// Serial management pins
	input  wire logic        spi_sclk_i,
	input  wire logic        spi_cs_n_i,
	input  wire logic        spi_mosi_i,
	output logic             spi_miso_o,
	output logic             spi_miso_oe_o,
	// Straps
	input  wire logic        port5_indicator1_strap_pin_i,
	input  wire logic        mii_rx_data3_strap_pin_i,
	// PHY-mode MII outputs from the core and to the pins
	input  wire logic [5:0]  mii_core_out_i,
	output logic [5:0]       mii_out_o,
	output logic [5:0]       mii_out_oe_o,
	// Frame classification
	input  wire logic        frame_valid_i,
	input  wire logic [2:0]  frame_user_prio_i,
	input  wire logic [15:0] frame_type_len_i,
	input  wire logic [47:0] frame_da_i,
	input  wire logic        frame_is_flow_ctrl_i,
	input  wire logic        frame_errored_i,
	input  wire logic [15:0] frame_actual_len_i,
	output logic             frame_high_prio_o,
	output logic             frame_drop_o,
	// Buffer and flow control
	output logic [15:0]      port_buffer_limit_o,
	input  wire logic [4:0]  an_tx_fc_i,
	input  wire logic [4:0]  an_rx_fc_i,
	output logic [4:0]       tx_fc_en_o,
	output logic [4:0]       rx_fc_en_o,
	// Aging
	input  wire logic [4:0]  port_link_up_i,
	output logic             age_flush_all_o,
	output logic             fast_age_busy_o,
	output logic             age_period_tick_o,
	output logic             pass_all_o
);
	import sgc_pkg::*;

	// ****************************************
	// Reset release and strap capture
	// ****************************************
	logic [1:0] rst_sync;
	logic       rst_n;
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rst_sync <= 2'b00;
		end else begin
			rst_sync <= {rst_sync[0], 1'b1};
		end
	end
	assign rst_n = rst_sync[1];

	logic [1:0] strap_a;
	logic [1:0] strap_b;
	logic [1:0] settle;
	logic       strap_load;
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			strap_a <= 2'b10;
			strap_b <= 2'b10;
			settle  <= 2'd0;
		end else begin
			strap_a <= {port5_indicator1_strap_pin_i, mii_rx_data3_strap_pin_i};
			strap_b <= strap_a;
			if (settle != 2'(STRAP_SETTLE_CYC)) begin
				settle <= settle + 2'd1;
			end
		end
	end
	// One-cycle load once the strap synchronisers hold pin values
	assign strap_load = (settle == 2'(STRAP_SETTLE_CYC - 1));

	// ****************************************
	// Register bank
	// ****************************************
	sgc_reg_if bus ();

	sgc_spi_slave u_spi (
		.clk_i         (clk_i),
		.rst_n_i       (rst_n),
		.spi_sclk_i    (spi_sclk_i),
		.spi_cs_n_i    (spi_cs_n_i),
		.spi_mosi_i    (spi_mosi_i),
		.spi_miso_o    (spi_miso_o),
		.spi_miso_oe_o (spi_miso_oe_o),
		.bus           (bus)
	);

	logic [7:0] global_control_zero;
	logic [7:0] next_global_control_zero;
	logic [7:0] global_control_one;
	logic [7:0] next_global_control_one;

	always_comb begin
		next_global_control_zero = global_control_zero;
		next_global_control_one  = global_control_one;
		if (strap_load) begin
			next_global_control_zero[GC0_PHY_MII_BIT] = strap_b[1];
			next_global_control_one[GC1_TX_FC_DIS_BIT] = strap_b[0];
			next_global_control_one[GC1_RX_FC_DIS_BIT] = strap_b[0];
		end else if (bus.wr_en) begin
			if (bus.addr == ADDR_GLOBAL_CONTROL_ZERO) begin
				next_global_control_zero = bus.wdata;
			end
			if (bus.addr == ADDR_GLOBAL_CONTROL_ONE) begin
				next_global_control_one = bus.wdata & GC1_IMPL_MASK;
			end
		end
	end

	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			global_control_zero <= GC0_RESET;
			global_control_one  <= GC1_RESET;
		end else begin
			global_control_zero <= next_global_control_zero;
			global_control_one  <= next_global_control_one;
		end
	end

	assign bus.rdata = (bus.addr == ADDR_GLOBAL_CONTROL_ZERO) ? global_control_zero :
		(bus.addr == ADDR_GLOBAL_CONTROL_ONE) ? global_control_one : 8'h00;

	// ****************************************
	// Field decode
	// ****************************************
	logic [2:0] base_prio;
	logic       mii_en;
	logic       share;
	logic       interop_test_drop_mode;
	logic       link_age;
	logic       tx_fc_dis;
	logic       rx_fc_dis;
	logic       len_chk;
	assign base_prio = global_control_zero[GC0_PRIO_LSB +: 3];
	assign mii_en    = global_control_zero[GC0_PHY_MII_BIT];
	assign share     = global_control_zero[GC0_SHARE_BIT];
	assign interop_test_drop_mode = global_control_zero[GC0_INTEROP_BIT];
	assign link_age  = global_control_zero[GC0_LINK_AGE_BIT];
	assign pass_all_o = global_control_one[GC1_PASS_ALL_BIT];
	assign tx_fc_dis = global_control_one[GC1_TX_FC_DIS_BIT];
	assign rx_fc_dis = global_control_one[GC1_RX_FC_DIS_BIT];
	assign len_chk   = global_control_one[GC1_LEN_CHK_BIT];

	assign mii_out_o    = mii_en ? mii_core_out_i : 6'h00;
	assign mii_out_oe_o = {6{mii_en}};

	// ****************************************
	// Frame decisions (fields read live, so writes act on the next frame)
	// ****************************************
	logic next_high;
	logic next_drop;
	logic ctrl_drop;
	logic len_drop;
	always_comb begin
		next_high = frame_valid_i ? (frame_user_prio_i >= base_prio) : frame_high_prio_o;
		ctrl_drop = interop_test_drop_mode ?
			((frame_type_len_i == FLOW_CTRL_TYPE) || (frame_da_i == FLOW_CTRL_DA)) :
			frame_is_flow_ctrl_i;
		len_drop = len_chk && (frame_type_len_i < MAX_LEN_FIELD) &&
			(frame_type_len_i != frame_actual_len_i);
		next_drop = frame_valid_i ?
			(ctrl_drop | len_drop | (frame_errored_i & ~pass_all_o)) : frame_drop_o;
	end

	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			frame_high_prio_o <= 1'b0;
			frame_drop_o      <= 1'b0;
		end else begin
			frame_high_prio_o <= next_high;
			frame_drop_o      <= next_drop;
		end
	end

	assign port_buffer_limit_o = share ? 16'(POOL_BLOCKS) : 16'(POOL_BLOCKS / NUM_PORTS);

	assign tx_fc_en_o = an_tx_fc_i & {5{~tx_fc_dis}};
	assign rx_fc_en_o = an_rx_fc_i & {5{~rx_fc_dis}};

	// ****************************************
	// Aging timer
	// ****************************************
	typedef enum logic {
		SGC_AGE_NORMAL = 1'b0,
		SGC_AGE_FAST   = 1'b1
	} sgc_age_t;

	sgc_age_t   age_st;
	sgc_age_t   next_age_st;
	logic [4:0] link_d;
	logic       link_lost;
	logic [16:0] fast_cnt;
	logic [16:0] next_fast_cnt;
	logic [16:0] div_cnt;
	logic [16:0] next_div_cnt;
	logic [18:0] ms_cnt;
	logic [18:0] next_ms_cnt;
	logic        ms_tick;
	logic        next_flush;
	logic        next_period;

	assign link_lost = link_age && |(link_d & ~port_link_up_i);
	assign ms_tick   = (div_cnt == 17'(MS_TICK_CYCLES - 1));

	always_comb begin
		next_age_st   = age_st;
		next_fast_cnt = fast_cnt;
		next_div_cnt  = ms_tick ? 17'd0 : div_cnt + 17'd1;
		next_ms_cnt   = ms_cnt;
		next_flush    = 1'b0;
		next_period   = 1'b0;
		if (link_lost) begin
			next_age_st   = SGC_AGE_FAST;
			next_fast_cnt = 17'd0;
			next_flush    = 1'b1;
		end else begin
			unique case (age_st)
				SGC_AGE_FAST: begin
					next_fast_cnt = fast_cnt + 17'd1;
					if (fast_cnt == 17'(FAST_AGE_CYCLES - 1)) begin
						next_age_st = SGC_AGE_NORMAL;
						next_ms_cnt = 19'd0;
					end
				end
				SGC_AGE_NORMAL: begin
					if (ms_tick) begin
						next_ms_cnt = ms_cnt + 19'd1;
						if (ms_cnt == 19'(NORMAL_AGE_MSEC - 1)) begin
							next_ms_cnt = 19'd0;
							next_period = 1'b1;
						end
					end
				end
			endcase
		end
	end

	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			age_st            <= SGC_AGE_NORMAL;
			link_d            <= 5'h00;
			fast_cnt          <= 17'd0;
			div_cnt           <= 17'd0;
			ms_cnt            <= 19'd0;
			age_flush_all_o   <= 1'b0;
			age_period_tick_o <= 1'b0;
		end else begin
			age_st            <= next_age_st;
			link_d            <= port_link_up_i;
			fast_cnt          <= next_fast_cnt;
			div_cnt           <= next_div_cnt;
			ms_cnt            <= next_ms_cnt;
			age_flush_all_o   <= next_flush;
			age_period_tick_o <= next_period;
		end
	end

	assign fast_age_busy_o = (age_st == SGC_AGE_FAST);
endmodule : sgc_top

//--- tb/sgc_checker.sv
// Port-level checks for the global control register block.
// Bound to sgc_top; parameters follow the bound instance.
`timescale 1ns/1ns
module sgc_checker #(
	parameter int POOL_BLOCKS     = 512,
	parameter int FAST_AGE_CYCLES = 20
) (
	input wire logic        clk_i,
	input wire logic        reset_n_i,
	input wire logic        spi_cs_n_i,
	input wire logic        spi_miso_oe_o,
	input wire logic [5:0]  mii_core_out_i,
	input wire logic [5:0]  mii_out_o,
	input wire logic [5:0]  mii_out_oe_o,
	input wire logic        frame_valid_i,
	input wire logic        frame_errored_i,
	input wire logic        frame_high_prio_o,
	input wire logic [15:0] port_buffer_limit_o,
	input wire logic [4:0]  an_tx_fc_i,
	input wire logic [4:0]  an_rx_fc_i,
	input wire logic [4:0]  tx_fc_en_o,
	input wire logic [4:0]  rx_fc_en_o,
	input wire logic [4:0]  port_link_up_i,
	input wire logic        age_flush_all_o,
	input wire logic        fast_age_busy_o,
	input wire logic        age_period_tick_o,
	input wire logic        pass_all_o,
	input wire logic        frame_drop_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);
	// ********
	// Helper state
	// ********
	logic [4:0] link_q;
	logic       fell_q;
	int         busy_cnt;
	// Links assumed up in reset; a false fall only relaxes the cause check
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			link_q   <= 5'h1f;
			fell_q   <= 1'b0;
			busy_cnt <= 0;
		end else begin
			link_q   <= port_link_up_i;
			fell_q   <= |(link_q & ~port_link_up_i);
			busy_cnt <= fast_age_busy_o ? busy_cnt + 1 : 0;
		end
	end
	// ********
	// Assertions
	// ********
	a_mii_drive_on: assert property (
		mii_out_oe_o[0] |-> mii_out_oe_o == 6'h3f && mii_out_o == mii_core_out_i)
		else $error("MII outputs not passed through while enabled");
	a_mii_float_off: assert property (
		!mii_out_oe_o[0] |-> mii_out_oe_o == 6'h00 && mii_out_o == 6'h00)
		else $error("MII outputs driven while isolated");
	a_prio_hold: assert property (
		!frame_valid_i |=> $stable(frame_high_prio_o))
		else $error("Priority class changed without a frame");
	a_err_frame_drop: assert property (
		frame_valid_i && frame_errored_i && !pass_all_o |=> frame_drop_o)
		else $error("Errored frame kept without pass-all");
	a_tx_fc_gate: assert property ((tx_fc_en_o & ~an_tx_fc_i) == 5'h00)
		else $error("Transmit flow control on without negotiation");
	a_rx_fc_gate: assert property ((rx_fc_en_o & ~an_rx_fc_i) == 5'h00)
		else $error("Receive flow control on without negotiation");
	a_buffer_limit: assert property (
		port_buffer_limit_o == 16'(POOL_BLOCKS) || port_buffer_limit_o == 16'(POOL_BLOCKS / 5))
		else $error("Buffer limit neither whole pool nor a fifth");
	a_flush_cause: assert property (age_flush_all_o |-> fell_q || $past(fell_q))
		else $error("Address flush without a link loss");
	a_flush_single: assert property (age_flush_all_o |=> !age_flush_all_o)
		else $error("Address flush longer than one cycle");
	a_fast_age_bound: assert property (
		fast_age_busy_o |-> busy_cnt < FAST_AGE_CYCLES)
		else $error("Fast aging ran too long");
	a_tick_quiet: assert property (fast_age_busy_o |-> !age_period_tick_o)
		else $error("Normal aging tick during fast aging");
	a_miso_deselect: assert property (spi_cs_n_i [*6] |-> !spi_miso_oe_o)
		else $error("Serial output driven while deselected");
	c_flush: cover property (age_flush_all_o);
	c_drop: cover property (frame_valid_i ##1 frame_drop_o);
	c_read: cover property (spi_miso_oe_o);
endmodule : sgc_checker

bind sgc_top sgc_checker #(.POOL_BLOCKS(POOL_BLOCKS), .FAST_AGE_CYCLES(FAST_AGE_CYCLES)) u_chk (
	.clk_i, .reset_n_i, .spi_cs_n_i, .spi_miso_oe_o, .mii_core_out_i, .mii_out_o,
	.mii_out_oe_o, .frame_valid_i, .frame_errored_i, .frame_high_prio_o, .port_buffer_limit_o,
	.an_tx_fc_i, .an_rx_fc_i, .tx_fc_en_o, .rx_fc_en_o, .port_link_up_i, .age_flush_all_o,
	.fast_age_busy_o, .age_period_tick_o, .pass_all_o, .frame_drop_o);

//--- tb/sgc_spi_host.sv
// Host controller model on the serial management pins, mode 0.
// Clocked by the core clock; SCLK is slow enough for the pin synchronisers.
`timescale 1ns/1ns
module sgc_spi_host (
	input  wire logic clk_i,
	output logic      sclk_o,
	output logic      cs_n_o,
	output logic      mosi_o,
	input  wire logic miso_i
);
	localparam int HALF = 8;
	initial begin
		sclk_o = 1'b0;
		cs_n_o = 1'b1;
		mosi_o = 1'b0;
	end
	task automatic wait_n(input int n);
		repeat (n) @(negedge clk_i);
	endtask : wait_n
	task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
		for (int i = 7; i >= 0; i--) begin
			mosi_o = tx[i];
			wait_n(HALF);
			sclk_o = 1'b1;
			rx[i] = miso_i;
			wait_n(HALF);
			sclk_o = 1'b0;
		end
	endtask : xfer
	task automatic txn(input logic [7:0] cmd, input logic [7:0] adr, input logic [7:0] d0,
		input logic [7:0] d1, output logic [7:0] r0, output logic [7:0] r1);
		logic [7:0] junk;
		@(negedge clk_i);
		cs_n_o = 1'b0;
		wait_n(HALF);
		xfer(cmd, junk);
		xfer(adr, junk);
		xfer(d0, r0);
		xfer(d1, r1);
		wait_n(HALF);
		cs_n_o = 1'b1;
		// Released line flips so stale data is never read as valid
		mosi_o = ~mosi_o;
		wait_n(HALF);
	endtask : txn
endmodule : sgc_spi_host

//--- tb/test_switch_global_control_regs.sv
// Self-checking bench for the global control register block.
// Inputs change at falling edges; registers are reached through the host model.
`timescale 1ns/1ns
module test_switch_global_control_regs;
	import sgc_pkg::*;
	localparam int POOL = 512;
	localparam int FAST = 20;
	localparam int MS   = 4;
	localparam int NMS  = 3;
	logic        clk_i = 1'b0;
	logic        reset_n_i = 1'b0;
	logic        spi_sclk_i, spi_cs_n_i, spi_mosi_i, spi_miso_o, spi_miso_oe_o, miso_line;
	logic        port5_indicator1_strap_pin_i = 1'b1;
	logic        mii_rx_data3_strap_pin_i = 1'b1;
	logic [5:0]  mii_core_out_i = 6'h00;
	logic [5:0]  mii_out_o, mii_out_oe_o;
	logic        frame_valid_i = 1'b0, frame_is_flow_ctrl_i = 1'b0, frame_errored_i = 1'b0;
	logic [2:0]  frame_user_prio_i = 3'h0;
	logic [15:0] frame_type_len_i = 16'h0000, frame_actual_len_i = 16'h0000;
	logic [15:0] port_buffer_limit_o;
	logic [47:0] frame_da_i = 48'h0000_0000_0000;
	logic        frame_high_prio_o, frame_drop_o, age_flush_all_o, fast_age_busy_o;
	logic        age_period_tick_o, pass_all_o;
	logic [4:0]  an_tx_fc_i = 5'h1f, an_rx_fc_i = 5'h1f, port_link_up_i = 5'h1f;
	logic [4:0]  tx_fc_en_o, rx_fc_en_o;
	logic [7:0]  r0, r1;
	int          num_errors = 0, checks_done = 0, cycles = 0, gc0, gc1;

	always #5 clk_i = ~clk_i;
	assign miso_line = spi_miso_oe_o ? spi_miso_o : 1'bz;

	sgc_top #(.POOL_BLOCKS(POOL), .FAST_AGE_CYCLES(FAST), .MS_TICK_CYCLES(MS),
		.NORMAL_AGE_MSEC(NMS)) u_dut (
		.clk_i, .reset_n_i, .spi_sclk_i, .spi_cs_n_i, .spi_mosi_i, .spi_miso_o, .spi_miso_oe_o,
		.port5_indicator1_strap_pin_i, .mii_rx_data3_strap_pin_i, .mii_core_out_i, .mii_out_o,
		.mii_out_oe_o, .frame_valid_i, .frame_user_prio_i, .frame_type_len_i, .frame_da_i,
		.frame_is_flow_ctrl_i, .frame_errored_i, .frame_actual_len_i, .frame_high_prio_o,
		.frame_drop_o, .port_buffer_limit_o, .an_tx_fc_i, .an_rx_fc_i, .tx_fc_en_o, .rx_fc_en_o,
		.port_link_up_i, .age_flush_all_o, .fast_age_busy_o, .age_period_tick_o, .pass_all_o);
	sgc_spi_host host (.clk_i, .sclk_o(spi_sclk_i), .cs_n_o(spi_cs_n_i), .mosi_o(spi_mosi_i),
		.miso_i(miso_line));

	// ********
	// Checking tasks
	// ********
	task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
		checks_done++;
		if (got !== exp) begin
			num_errors++;
			$display("ERROR %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	task automatic rd_chk();
		host.txn(SPI_CMD_READ, ADDR_GLOBAL_CONTROL_ZERO, 8'h00, 8'h00, r0, r1);
		chk("gc0", 16'(gc0), 16'(r0));
		chk("gc1", 16'(gc1), 16'(r1));
	endtask : rd_chk
	task automatic chk_fields();
		@(negedge clk_i);
		chk("mii_oe", 16'({6{gc0[3]}}), 16'(mii_out_oe_o));
		chk("mii_out", 16'(gc0[3] ? mii_core_out_i : 6'h00), 16'(mii_out_o));
		chk("buf_limit", 16'(gc0[2] ? POOL : POOL / 5), port_buffer_limit_o);
		chk("tx_fc", 16'(an_tx_fc_i & ~{5{gc1[5]}}), 16'(tx_fc_en_o));
		chk("rx_fc", 16'(an_rx_fc_i & ~{5{gc1[4]}}), 16'(rx_fc_en_o));
		chk("pass_all", 16'(gc1[7]), 16'(pass_all_o));
	endtask : chk_fields
	task automatic frame_chk();
		int  sel;
		logic drop;
		sel = $urandom_range(3);
		frame_user_prio_i = 3'($urandom);
		frame_type_len_i = sel == 0 ? FLOW_CTRL_TYPE : 16'($urandom_range(sel == 1 ? 1499 : 65535));
		frame_da_i = sel == 2 ? FLOW_CTRL_DA : 48'({$urandom, $urandom});
		frame_is_flow_ctrl_i = 1'($urandom);
		frame_errored_i = 1'($urandom);
		frame_actual_len_i = $urandom_range(1) ? frame_type_len_i : 16'($urandom);
		frame_valid_i = 1'b1;
		@(negedge clk_i);
		drop = (frame_errored_i && !gc1[7]) || (gc1[3] && frame_type_len_i < MAX_LEN_FIELD &&
			frame_actual_len_i != frame_type_len_i) || (gc0[1] ? (frame_type_len_i ==
			FLOW_CTRL_TYPE || frame_da_i == FLOW_CTRL_DA) : frame_is_flow_ctrl_i);
		chk("high_prio", 16'(frame_user_prio_i >= gc0[6:4]), 16'(frame_high_prio_o));
		chk("drop", 16'(drop), 16'(frame_drop_o));
	endtask : frame_chk
	task automatic age_run(input int la);
		int nfl, nbusy, t1, t2;
		nfl = 0;
		nbusy = 0;
		t1 = -1;
		t2 = -1;
		gc0 = (gc0 & 'hfe) | la;
		host.txn(SPI_CMD_WRITE, ADDR_GLOBAL_CONTROL_ZERO, 8'(gc0), 8'(gc1), r0, r1);
		repeat (40) @(negedge clk_i);
		port_link_up_i[$urandom_range(4)] = 1'b0;
		for (int c = 0; c < 80; c++) begin
			@(negedge clk_i);
			nfl += int'(age_flush_all_o);
			nbusy += int'(fast_age_busy_o);
			if (age_period_tick_o && nbusy > 0 && !fast_age_busy_o) begin
				if (t1 < 0) t1 = c;
				else if (t2 < 0) t2 = c;
			end
		end
		chk("flush_count", 16'(la), 16'(nfl));
		chk("fast_age", 16'(la), 16'(nbusy >= 1 && nbusy <= FAST));
		if (la) chk("age_period", 16'(MS * NMS), 16'(t2 - t1));
		port_link_up_i = 5'h1f;
	endtask : age_run
	task automatic stop_test();
		if (num_errors == 0 && checks_done > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : stop_test

	// ********
	// Main sequence
	// ********
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 60000) begin
			num_errors++;
			stop_test();
		end
	end
	initial begin
		gc0 = $urandom(83);
		for (int s = 0; s < 2; s++) begin
			port5_indicator1_strap_pin_i = s[0];
			mii_rx_data3_strap_pin_i = ~s[0];
			reset_n_i = 1'b0;
			repeat (4) @(negedge clk_i);
			reset_n_i = 1'b1;
			repeat (12) @(negedge clk_i);
			gc0 = 'h44 | (s << 3);
			gc1 = s ? 'h00 : 'h30;
			rd_chk();
			chk_fields();
		end
		for (int i = 0; i < 8; i++) begin
			gc0 = $urandom_range(255);
			gc1 = $urandom_range(255);
			an_tx_fc_i = 5'($urandom);
			an_rx_fc_i = 5'($urandom);
			mii_core_out_i = 6'($urandom);
			host.txn(SPI_CMD_WRITE, ADDR_GLOBAL_CONTROL_ZERO, 8'(gc0), 8'(gc1), r0, r1);
			gc1 = gc1 & GC1_IMPL_MASK;
			rd_chk();
			chk_fields();
			repeat (6) frame_chk();
			frame_valid_i = 1'b0;
		end
		host.txn(SPI_CMD_WRITE, 8'h04, 8'hff, 8'hff, r0, r1);
		host.txn(SPI_CMD_READ, 8'h04, 8'h00, 8'h00, r0, r1);
		chk("unmapped", 16'h0000, 16'({r0, r1}));
		rd_chk();
		age_run(1);
		age_run(0);
		stop_test();
	end
endmodule : test_switch_global_control_regs
